// ### hdl/tea_consts.vh
`ifndef TEA_CONSTS_VH
`define TEA_CONSTS_VH
// APB register byte offsets.
`define TEA_OFF_CTRL 12'h000
`define TEA_OFF_STATUS 12'h004
`define TEA_OFF_ERRLOG 12'h008
`define TEA_OFF_HDR0 12'h010
`define TEA_OFF_HDR1 12'h014
`define TEA_OFF_HDR2 12'h018
`define TEA_OFF_HDR3 12'h01c
`define TEA_OFF_COUNT 12'h020
// Control register fields.
`define TEA_CTRL_DSP 0
`define TEA_CTRL_ACS_SEV 1
`define TEA_CTRL_RESET 32'h00000000
// Status register fields.
`define TEA_ST_STA 0
`define TEA_ST_PRI_DPE 1
`define TEA_ST_SEC_DPE 2
`define TEA_ST_UNCOR 3
`define TEA_ST_COR 4
`define TEA_ST_INTERNAL 5
`define TEA_ST_HDR_VALID 6
`define TEA_STATUS_RESET 32'h00000000
// Top of the saturating count of errors not tied to a received packet.
`define TEA_COUNT_MAX 16'hffff
// Error priority levels, highest first.
`define TEA_PRI_OVF 3'h7
`define TEA_PRI_ECRC 3'h6
`define TEA_PRI_MAL 3'h5
`define TEA_PRI_ACS 3'h4
`define TEA_PRI_MC 3'h3
`define TEA_PRI_UR 3'h2
`define TEA_PRI_POIS 3'h1
`define TEA_PRI_NONE 3'h0
`endif

// ### hdl/tea_prio.v
`timescale 1ns/1ns
`include "tea_consts.vh"
// Picks the highest level among the received-TLP errors.
module tea_prio (
    input wire [7:1] err_vec,
    output reg [2:0] level
);
    integer i;

    // Scan upward so the highest set bit wins; same-level errors never
    // meet on one packet, so a single bit per level is enough.
    always @* begin
        level = `TEA_PRI_NONE;
        for (i = 1; i <= 7; i = i + 1) begin
            if (err_vec[i]) begin
                level = i[2:0];
            end
        end
    end
endmodule

// ### hdl/tea_hdr_mem.v
`timescale 1ns/1ns
// Four-word store for the logged offending header.
module tea_hdr_mem (
    input wire pclk,
    input wire presetn,
    input wire wr_en,
    input wire [127:0] wr_data,
    input wire [1:0] rd_addr,
    output reg [31:0] rd_data
);
    reg [31:0] mem [0:3];
    integer k;

    // Whole header is written at once; read data leaves a register.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (k = 0; k < 4; k = k + 1) begin
                mem[k] <= 32'h00000000;
            end
            rd_data <= 32'h00000000;
        end else begin
            if (wr_en) begin
                mem[0] <= wr_data[31:0];
                mem[1] <= wr_data[63:32];
                mem[2] <= wr_data[95:64];
                mem[3] <= wr_data[127:96];
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ### hdl/tea_logger.v
`timescale 1ns/1ns
`include "tea_consts.vh"
// How it works
// - ACS checks only in downstream port mode.
// - Redirect is no error, nothing logged.
// - Blocking is an ACS violation, logged.
// - Local and gathered messages skip source validation.
// - Non-posted violation returns completer abort completion.
// - Non-posted violation sets signaled target abort.
// - Advisory only when nonfatal and non-posted.
// - Violations log header and drop the TLP.
// - Three violation kinds share one treatment.
// - Direct translated failure uses egress, redirect rules.
// - Prioritize only received-TLP errors, others always.
// - Internal errors bypass prioritization and always log.
// - Poisoned TLP always sets parity flag.
// - Rank: overflow, ECRC, malformed, ACS, multicast, UR, poison.
// - Same-level errors never coincide, no arbitration.
// - Log only the highest-priority error.
// - Lower checks run unless TLP already consumed.
module tea_logger (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire tlp_valid,
    input wire [127:0] tlp_header,
    input wire tlp_non_posted,
    input wire tlp_local_or_gathered_msg,
    input wire tlp_from_secondary,
    input wire tlp_poisoned,
    input wire err_rx_overflow,
    input wire err_ecrc,
    input wire ecrc_drops_tlp,
    input wire err_malformed,
    input wire acs_src_valid_fail,
    input wire acs_trans_block_fail,
    input wire acs_p2p_egress_fail,
    input wire acs_direct_p2p_fail,
    input wire acs_p2p_redirect_on,
    input wire err_mc_blocked,
    input wire err_unsupported,
    input wire err_unexp_cpl,
    input wire err_internal,
    input wire err_not_rx,
    output reg acs_redirect,
    output reg tlp_drop,
    output reg cpl_ca_req,
    output reg ur_handle,
    output reg err_report_uncor,
    output reg err_report_cor,
    output reg [2:0] err_report_level
);
    reg [31:0] ctrl;
    reg [31:0] status;
    reg [2:0] last_level;
    reg [15:0] nonrx_count;
    wire apb_wr;
    wire is_dsp;
    wire acs_sev_fatal;
    wire dsp_src;
    wire acs_block;
    wire [7:1] err_vec;
    wire [2:0] level;
    wire consumed_above_acs;
    wire acs_logged;
    wire advisory;
    wire hdr_we;
    wire [31:0] hdr_rd;
    reg [1:0] hdr_sel;
    reg [31:0] next_status;
    reg [2:0] bus_state;
    reg [2:0] next_bus_state;
    wire setup_phase;
    wire hdr_read;

    // Slave phases, one-hot. A header read spends one extra cycle in
    // the wait phase while the header store's output register fills.
    localparam BUS_IDLE = 3'b001;
    localparam BUS_WAIT = 3'b010;
    localparam BUS_DONE = 3'b100;

    // True for the four word offsets of the logged header. Any other
    // offset is served from the plain registers in the setup phase.
    function is_hdr_addr;
        input [11:0] addr;
        begin
            is_hdr_addr = (addr == `TEA_OFF_HDR0) ||
                (addr == `TEA_OFF_HDR1) || (addr == `TEA_OFF_HDR2) ||
                (addr == `TEA_OFF_HDR3);
        end
    endfunction

    // Word of the header store that a header offset selects.
    function [1:0] hdr_word;
        input [11:0] addr;
        begin
            case (addr)
                `TEA_OFF_HDR1: hdr_word = 2'h1;
                `TEA_OFF_HDR2: hdr_word = 2'h2;
                `TEA_OFF_HDR3: hdr_word = 2'h3;
                default: hdr_word = 2'h0;
            endcase
        end
    endfunction

    // True when a completing write targets the register at offset.
    function reg_write;
        input strobe;
        input [11:0] addr;
        input [11:0] offset;
        begin
            reg_write = strobe && (addr == offset);
        end
    endfunction

    // Saturating increment, so a storm of events never wraps to zero and
    // a busy link still shows that errors happened.
    function [15:0] sat_inc;
        input [15:0] value;
        begin
            if (value == `TEA_COUNT_MAX) begin
                sat_inc = value;
            end else begin
                sat_inc = value + 16'h0001;
            end
        end
    endfunction

    // Register write occurs only in the access phase of an APB transfer.
    assign apb_wr = psel && penable && pwrite && pready;
    // Setup phase of any transfer, and the one kind that needs a wait.
    assign setup_phase = psel && !penable;
    assign hdr_read = setup_phase && !pwrite && is_hdr_addr(paddr);
    assign is_dsp = ctrl[`TEA_CTRL_DSP];
    assign acs_sev_fatal = ctrl[`TEA_CTRL_ACS_SEV];

    // Source validation is not applied to local or gathered messages.
    assign dsp_src = acs_src_valid_fail && !tlp_local_or_gathered_msg;
    // A direct translated failure falls to egress control unless the
    // redirect control takes it, in which case it is rerouted instead.
    assign acs_block = is_dsp && (dsp_src || acs_trans_block_fail ||
        acs_p2p_egress_fail ||
        (acs_direct_p2p_fail && !acs_p2p_redirect_on));

    // Each level carries one bit; unexpected completion joins level 2.
    assign err_vec = {err_rx_overflow, err_ecrc, err_malformed, acs_block,
        err_mc_blocked, (err_unsupported || err_unexp_cpl),
        tlp_poisoned};

    tea_prio u_prio (
        .err_vec(err_vec),
        .level(level)
    );

    // Overflow, malformed or a dropping ECRC error consume the packet, so
    // the blocking path below them has nothing left to act on.
    assign consumed_above_acs = err_rx_overflow || err_malformed ||
        (err_ecrc && ecrc_drops_tlp);
    // A blocked TLP is logged as ACS only when it is the top error.
    assign acs_logged = (level == `TEA_PRI_ACS);
    assign advisory = !acs_sev_fatal && tlp_non_posted;
    assign hdr_we = tlp_valid && acs_logged;

    tea_hdr_mem u_hdr (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(hdr_we),
        .wr_data(tlp_header),
        .rd_addr(hdr_sel),
        .rd_data(hdr_rd)
    );

    // Header word select follows the address in the setup phase, so the
    // memory register holds the word by the wait phase.
    always @* begin
        hdr_sel = hdr_word(paddr);
    end

    // Sticky status; hardware sets win over a software clear in the
    // same cycle. Writing one clears a bit.
    always @* begin
        next_status = status;
        if (reg_write(apb_wr, paddr, `TEA_OFF_STATUS)) begin
            next_status = status & ~pwdata;
        end
        if (tlp_valid) begin
            if (acs_block && tlp_non_posted && acs_logged) begin
                next_status[`TEA_ST_STA] = 1'b1;
            end
            if (tlp_poisoned && !tlp_from_secondary) begin
                next_status[`TEA_ST_PRI_DPE] = 1'b1;
            end
            if (tlp_poisoned && tlp_from_secondary) begin
                next_status[`TEA_ST_SEC_DPE] = 1'b1;
            end
            if (level != `TEA_PRI_NONE) begin
                if (acs_logged && advisory) begin
                    next_status[`TEA_ST_COR] = 1'b1;
                end else begin
                    next_status[`TEA_ST_UNCOR] = 1'b1;
                end
            end
            if (hdr_we) begin
                next_status[`TEA_ST_HDR_VALID] = 1'b1;
            end
        end
        // Internal errors are logged beside any prioritized one.
        if (err_internal) begin
            next_status[`TEA_ST_INTERNAL] = 1'b1;
        end
        next_status[31:7] = 25'h0;
    end

    // Control, status, logged level and the non-received-error counter.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `TEA_CTRL_RESET;
            status <= `TEA_STATUS_RESET;
            last_level <= `TEA_PRI_NONE;
            nonrx_count <= 16'h0000;
        end else begin
            status <= next_status;
            if (reg_write(apb_wr, paddr, `TEA_OFF_CTRL)) begin
                ctrl <= {30'h0, pwdata[1:0]};
            end
            if (tlp_valid && level != `TEA_PRI_NONE) begin
                last_level <= level;
            end
            // Errors not tied to a received TLP log on every occurrence.
            if (err_not_rx) begin
                nonrx_count <= sat_inc(nonrx_count);
            end
        end
    end

    // Per-TLP actions, registered so every output leaves a flip-flop.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acs_redirect <= 1'b0;
            tlp_drop <= 1'b0;
            cpl_ca_req <= 1'b0;
            ur_handle <= 1'b0;
            err_report_uncor <= 1'b0;
            err_report_cor <= 1'b0;
            err_report_level <= `TEA_PRI_NONE;
        end else begin
            // Redirect only reroutes; it raises no error at all.
            acs_redirect <= tlp_valid && is_dsp && acs_direct_p2p_fail &&
                acs_p2p_redirect_on && !consumed_above_acs;
            // Blocking still drops under an undropped ECRC error.
            tlp_drop <= tlp_valid && (consumed_above_acs ||
                acs_block || err_mc_blocked);
            // The abort completion goes out only if ACS is the top error.
            cpl_ca_req <= tlp_valid && acs_logged &&
                tlp_non_posted;
            ur_handle <= tlp_valid && err_vec[2] && !consumed_above_acs &&
                !acs_block && !err_mc_blocked;
            err_report_uncor <= tlp_valid && level != `TEA_PRI_NONE &&
                !(acs_logged && advisory);
            err_report_cor <= tlp_valid && acs_logged && advisory;
            err_report_level <= tlp_valid ? level : `TEA_PRI_NONE;
        end
    end

    // Register map as software sees it, one aligned word each:
    //   0x000 control: bit 0 downstream mode, bit 1 ACS severity fatal.
    //   0x004 status, write one to clear: bit 0 signaled target abort,
    //         bits 1 and 2 primary and secondary parity error, bit 3
    //         uncorrectable, bit 4 correctable, bit 5 internal error,
    //         bit 6 header valid.
    //   0x008 level of the last error logged for a received packet.
    //   0x010 to 0x01c the four words of the last logged header.
    //   0x020 saturating count of errors not tied to a received packet.
    // Any other offset reads zero and answers with pslverr.

    // Next slave phase. A header read waits one cycle so that its word
    // can leave the header store's register; every other access is
    // answered at once, which keeps the common case free of wait states.
    always @* begin
        next_bus_state = bus_state;
        case (bus_state)
            BUS_IDLE: begin
                if (hdr_read) begin
                    next_bus_state = BUS_WAIT;
                end else if (setup_phase) begin
                    next_bus_state = BUS_DONE;
                end
            end
            BUS_WAIT: begin
                next_bus_state = BUS_DONE;
            end
            BUS_DONE: begin
                // The master samples pready here and the transfer ends.
                next_bus_state = BUS_IDLE;
            end
            default: begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    // APB slave outputs leave flip-flops. The ready flag stands for the
    // single cycle of the done phase and read data stand with it. A
    // header that is logged in the setup cycle of a read is missed by
    // that read; the next read returns it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state <= BUS_IDLE;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            bus_state <= next_bus_state;
            pready <= (next_bus_state == BUS_DONE);
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (bus_state == BUS_WAIT) begin
                // The header store has now registered the selected word.
                prdata <= hdr_rd;
            end else if (bus_state == BUS_IDLE && setup_phase) begin
                case (paddr)
                    `TEA_OFF_CTRL: prdata <= ctrl;
                    `TEA_OFF_STATUS: prdata <= next_status;
                    `TEA_OFF_ERRLOG: prdata <= {29'h0, last_level};
                    `TEA_OFF_COUNT: prdata <= {16'h0, nonrx_count};
                    // Header words come a cycle later from the store;
                    // header writes are accepted and ignored.
                    `TEA_OFF_HDR0,
                    `TEA_OFF_HDR1,
                    `TEA_OFF_HDR2,
                    `TEA_OFF_HDR3: prdata <= 32'h00000000;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule

// ### tb/tea_logger_properties.sv
`timescale 1ns/1ns
// Port relations of the logger, judged one cycle after each TLP.
module tea_logger_props (
    input wire pclk,
    input wire presetn,
    input wire tlp_valid,
    input wire tlp_non_posted,
    input wire tlp_poisoned,
    input wire err_rx_overflow,
    input wire err_ecrc,
    input wire err_malformed,
    input wire acs_redirect,
    input wire tlp_drop,
    input wire cpl_ca_req,
    input wire [2:0] err_report_level,
    input wire err_report_cor,
    input wire ur_handle
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Actions only ever follow a received TLP by one cycle.
    chk_result_cause: assert property (
        (acs_redirect || cpl_ca_req) |-> $past(tlp_valid))
        else $error("action without a tlp");
    chk_ca_nonposted: assert property (
        cpl_ca_req |-> $past(tlp_non_posted))
        else $error("abort completion for a posted tlp");
    chk_ca_drops: assert property (cpl_ca_req |-> tlp_drop)
        else $error("blocked tlp not dropped");
    chk_redirect_quiet: assert property (
        acs_redirect |-> !cpl_ca_req)
        else $error("redirect treated as violation");
    chk_ovf_top: assert property (
        tlp_valid && err_rx_overflow |=> err_report_level == 3'h7)
        else $error("overflow not top level");
    chk_ecrc_next: assert property (
        tlp_valid && !err_rx_overflow && err_ecrc
        |=> err_report_level == 3'h6)
        else $error("ecrc level wrong");
    chk_mal_drop: assert property (
        tlp_valid && err_malformed |=> tlp_drop)
        else $error("malformed tlp kept");
    // A higher error outranks ACS, so no abort completion follows.
    chk_ca_inhibit: assert property (
        cpl_ca_req |-> !$past(err_rx_overflow) && !$past(err_ecrc)
        && !$past(err_malformed))
        else $error("abort completion under higher error");
    chk_poison_cause: assert property (
        err_report_level == 3'h1 |-> $past(tlp_poisoned))
        else $error("poison level without poison");
    chk_cor_nonposted: assert property (
        err_report_cor |-> $past(tlp_non_posted))
        else $error("correctable report for a posted tlp");
    chk_ur_kept: assert property (ur_handle |-> !tlp_drop)
        else $error("unsupported handling on a dropped tlp");
endmodule

// ### tb/tea_link_model.sv
`timescale 1ns/1ns
// Link partner: presents one TLP with its check results per send.
module tea_link_model (
    input wire pclk,
    input wire send,
    input wire [15:0] fl,
    input wire [1:0] side,
    output reg tlp_valid,
    output reg [15:0] fo,
    output reg [1:0] so,
    output reg [127:0] hdr
);
    initial begin
        tlp_valid = 1'b0;
        fo = 16'h0000;
        so = 2'b00;
        hdr = 128'h0;
    end
    // Outside a TLP the qualifiers flip, so a stale copy is never seen.
    always @(posedge pclk) begin
        tlp_valid <= send;
        so <= side;
        fo <= send ? fl : ~fo;
        // Word k of the header carries the flags and its own index.
        hdr <= send ? {fl, 16'h0003, fl, 16'h0002, fl, 16'h0001, fl,
            16'h0000} : ~hdr;
    end
endmodule

// ### tb/tb.sv
`timescale 1ns/1ns
`include "tea_consts.vh"
module tb;
    reg pclk, presetn, psel, penable, pwrite, send, err;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [15:0] fl, v;
    reg [1:0] side;
    reg [8:0] out;
    wire [31:0] prdata;
    wire pready, pslverr, tv, ar, dr, ca, ur, eu, ec;
    wire [2:0] lv;
    wire [15:0] f;
    wire [1:0] so;
    wire [127:0] hdr;
    integer miscompares, checked, i, n;
    tea_link_model link (.pclk(pclk), .send(send), .fl(fl), .side(side),
        .tlp_valid(tv), .fo(f), .so(so), .hdr(hdr));
    tea_logger dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tlp_valid(tv), .tlp_header(hdr), .tlp_non_posted(f[0]),
        .tlp_local_or_gathered_msg(f[1]), .tlp_from_secondary(f[2]),
        .tlp_poisoned(f[3]), .err_rx_overflow(f[4]), .err_ecrc(f[5]),
        .ecrc_drops_tlp(f[6]), .err_malformed(f[7]),
        .acs_src_valid_fail(f[8]), .acs_trans_block_fail(f[9]),
        .acs_p2p_egress_fail(f[10]), .acs_direct_p2p_fail(f[11]),
        .acs_p2p_redirect_on(f[12]), .err_mc_blocked(f[13]),
        .err_unsupported(f[14]), .err_unexp_cpl(f[15]),
        .err_internal(so[0]), .err_not_rx(so[1]), .acs_redirect(ar),
        .tlp_drop(dr), .cpl_ca_req(ca), .ur_handle(ur),
        .err_report_uncor(eu), .err_report_cor(ec), .err_report_level(lv));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task summarize;
        begin
            if (miscompares == 0 && checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One APB transfer; the request holds until pready is sampled high.
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 20);
            if (pready !== 1'b1) begin
                miscompares = miscompares + 1;
                summarize;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rdchk(input [11:0] a, input [31:0] m, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            check(rd & m, e);
        end
    endtask
    // Sends one TLP (or side pulses only) and samples the result cycle.
    task tlp(input [15:0] fv, input [1:0] s, input o);
        begin
            @(posedge pclk);
            send <= o;
            fl <= fv;
            side <= s;
            @(posedge pclk);
            send <= 1'b0;
            side <= 2'b00;
            @(posedge pclk);
            #1;
            out = {ar, dr, ca, ur, eu, ec, lv};
        end
    endtask
    task t_regs;
        begin
            rdchk(`TEA_OFF_CTRL, 32'hffffffff, 32'h0);
            rdchk(`TEA_OFF_STATUS, 32'hffffffff, 32'h0);
            apb(1'b0, 12'h040, 32'h0);
            check(rd, 32'h0);
            check(err, 32'h1);
            tlp(16'h0101, 2'b00, 1'b1);
            check(out, 9'h000);
            apb(1'b1, `TEA_OFF_CTRL, 32'h1);
        end
    endtask
    // Each blocking kind, non-posted then posted, with status and clear.
    task t_block;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                tlp(16'h0101 << i | 16'h0001, 2'b00, 1'b1);
                check(out, 9'h0cc);
                rdchk(`TEA_OFF_STATUS, 32'h7f, 32'h51);
                apb(1'b1, `TEA_OFF_STATUS, 32'h7f);
                tlp(16'h0100 << i, 2'b00, 1'b1);
                check(out, 9'h094);
                rdchk(`TEA_OFF_STATUS, 32'h7f, 32'h48);
                apb(1'b1, `TEA_OFF_STATUS, 32'h7f);
            end
            rdchk(`TEA_OFF_ERRLOG, 32'h7, 32'h4);
            apb(1'b1, `TEA_OFF_CTRL, 32'h3);
            tlp(16'h0101, 2'b00, 1'b1);
            check(out, 9'h0d4);
            rdchk(`TEA_OFF_HDR0, 32'hffffffff, 32'h01010000);
            rdchk(`TEA_OFF_HDR3, 32'hffffffff, 32'h01010003);
            apb(1'b1, `TEA_OFF_CTRL, 32'h1);
        end
    endtask
    task t_redirect;
        begin
            tlp(16'h1801, 2'b00, 1'b1);
            check(out, 9'h100);
            tlp(16'h0801, 2'b00, 1'b1);
            check(out, 9'h0cc);
            tlp(16'h0102, 2'b00, 1'b1);
            check(out, 9'h000);
        end
    endtask
    // Errors stacked from poison upward; the top one sets the level.
    task t_prio;
        reg [15:0] pt [0:6];
        begin
            pt[0] = 16'h0010;
            pt[1] = 16'h0020;
            pt[2] = 16'h0080;
            pt[3] = 16'h0100;
            pt[4] = 16'h2000;
            pt[5] = 16'h4000;
            pt[6] = 16'h0008;
            v = 16'h0000;
            for (i = 6; i >= 0; i = i - 1) begin
                v = v | pt[i];
                tlp(v, 2'b00, 1'b1);
                check(lv, 7 - i);
            end
            tlp(16'h8000, 2'b00, 1'b1);
            check(lv, 3'h2);
            tlp(16'h0121, 2'b00, 1'b1);
            check(out & 9'h0c7, 9'h086);
            tlp(16'h4000, 2'b00, 1'b1);
            check(out, 9'h032);
            tlp(16'h4020, 2'b00, 1'b1);
            check(out, 9'h036);
            tlp(16'h4060, 2'b00, 1'b1);
            check(out, 9'h096);
        end
    endtask
    task t_side;
        begin
            apb(1'b1, `TEA_OFF_STATUS, 32'h7f);
            tlp(16'h0018, 2'b00, 1'b1);
            rdchk(`TEA_OFF_STATUS, 32'h6, 32'h2);
            apb(1'b1, `TEA_OFF_STATUS, 32'h7f);
            tlp(16'h001c, 2'b00, 1'b1);
            rdchk(`TEA_OFF_STATUS, 32'h6, 32'h4);
            tlp(16'h0008, 2'b01, 1'b1);
            check(lv, 3'h1);
            rdchk(`TEA_OFF_STATUS, 32'h20, 32'h20);
            tlp(16'h0000, 2'b10, 1'b0);
            tlp(16'h0000, 2'b10, 1'b0);
            rdchk(`TEA_OFF_COUNT, 32'hffffffff, 32'h2);
        end
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        send = 1'b0;
        fl = 16'h0000;
        side = 2'b00;
        miscompares = 0;
        checked = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_block;
        t_redirect;
        t_prio;
        t_side;
        summarize;
    end
endmodule
bind tea_logger tea_logger_props u_props (.pclk(pclk), .presetn(presetn),
    .tlp_valid(tlp_valid), .tlp_non_posted(tlp_non_posted),
    .tlp_poisoned(tlp_poisoned), .err_rx_overflow(err_rx_overflow),
    .err_ecrc(err_ecrc), .err_malformed(err_malformed),
    .acs_redirect(acs_redirect), .tlp_drop(tlp_drop),
    .cpl_ca_req(cpl_ca_req), .err_report_level(err_report_level),
    .err_report_cor(err_report_cor), .ur_handle(ur_handle));
